// ===== src/iebd_pkg.sv
// Purpose: constants shared by the IN endpoint X descriptor block
// Assumes: byte-wide register port, 100 MHz system clock
// Notes: register offsets are indices on a plain register port
package iebd_pkg;
  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] OFS_CNT = 4'h0;
  localparam logic [3:0] OFS_SIZ = 4'h1;
  localparam logic [3:0] OFS_BAX = 4'h2;
  localparam logic [3:0] OFS_CNF = 4'h3;
  localparam logic [3:0] OFS_IST = 4'h4;
  localparam logic [3:0] OFS_ICLR = 4'h5;
  localparam logic [3:0] OFS_IEN = 4'h6;
  localparam logic [3:0] OFS_STAT = 4'h7;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CNT_NAK_BIT = 7;
  localparam int CNT_W = 7;
  localparam int CNF_EN_BIT = 7;
  localparam int CNF_ISO_BIT = 6;
  localparam int CNF_TOG_BIT = 5;
  localparam int CNF_OVF_BIT = 5;
  localparam int CNF_DOUBLE_BUFFER_SELECT_BIT = 4;
  localparam int CNF_STALL_BIT = 3;
  localparam int BPS_W = 5;
  localparam int SIZE_SHIFT = 3;
  localparam int MEM_ADDR_W = 11;
  localparam int LEN_W = 13;
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_NAK = 1;
  localparam int IRQ_STALL = 2;
  localparam int IRQ_OVF = 3;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CNT = 8'h80;
  localparam logic [7:0] RST_SIZ = 8'h00;
  localparam logic [7:0] RST_BAX = 8'h00;
  localparam logic [7:0] RST_CNF = 8'h00;
  localparam logic [3:0] RST_IEN = 4'h0;
  // ----------------------------------------------------------------
  // transmit sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_SEND,
    ST_FIN,
    ST_WAIT_ACK
  } iebd_state_t;
endpackage : iebd_pkg

// ===== src/iebd_len_calc.sv
// Purpose: packet length in bytes from the X count
// Assumes: count and sample size from descriptor registers
// Notes: purely combinational
`timescale 1ns/10ps
module iebd_len_calc (
  input wire logic [iebd_pkg::CNT_W-1:0] count_i,
  input wire logic [iebd_pkg::BPS_W-1:0] bytes_per_sample_i,
  input wire logic iso_i,
  output logic [iebd_pkg::LEN_W-1:0] len_o
);
  import iebd_pkg::*;
  logic [5:0] sample_bytes;
  logic [LEN_W-1:0] iso_len;
  always_comb begin
    sample_bytes = {1'b0, bytes_per_sample_i} + 6'h01;
    iso_len = {6'h00, count_i} * {7'h00, sample_bytes};
    len_o = iso_i ? iso_len : {6'h00, count_i};
  end
endmodule : iebd_len_calc

// ===== src/iebd_addr_gen.sv
// Purpose: buffer byte address and next offset
// Assumes: base holds address bits 10:3
// Notes: iso offsets wrap at the buffer size
`timescale 1ns/10ps
module iebd_addr_gen (
  input wire logic [7:0] base_hi_i,
  input wire logic [7:0] size_units_i,
  input wire logic iso_i,
  input wire logic [iebd_pkg::MEM_ADDR_W-1:0] ofs_i,
  output logic [iebd_pkg::MEM_ADDR_W-1:0] addr_o,
  output logic [iebd_pkg::MEM_ADDR_W-1:0] size_bytes_o,
  output logic [iebd_pkg::MEM_ADDR_W-1:0] ofs_next_o
);
  import iebd_pkg::*;
  logic [MEM_ADDR_W-1:0] inc;
  always_comb begin
    size_bytes_o = {size_units_i, 3'h0};
    addr_o = {base_hi_i, 3'h0} + ofs_i;
    inc = ofs_i + 11'h001;
    ofs_next_o = (iso_i && inc >= size_bytes_o) ? 11'h000 : inc;
  end
endmodule : iebd_addr_gen

// ===== src/iebd_top.sv
// Purpose: IN endpoint X buffer descriptor and transmit sequencer
// Assumes: token, ack and fail strobes come from same-clock logic
// Notes: Y buffer is handled elsewhere; this block serves X only
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/10ps
module iebd_top (
  input wire logic SYS_CLK_I,
  input wire logic SRST_I,
  input wire logic [iebd_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [iebd_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [iebd_pkg::DATA_W-1:0] RDATA_O,
  input wire logic IN_TOKEN_I,
  input wire logic HOST_ACK_I,
  input wire logic TXN_FAIL_I,
  output logic NAK_O,
  output logic STALL_O,
  output logic [iebd_pkg::MEM_ADDR_W-1:0] MEM_ADDR_O,
  output logic MEM_RD_O,
  input wire logic [7:0] MEM_DATA_I,
  output logic [7:0] TX_DATA_O,
  output logic TX_VALID_O,
  output logic TX_END_O,
  output logic TX_PID1_O,
  output logic IRQ_O
);
  import iebd_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] siz_q, siz_d;
  logic [7:0] bax_q, bax_d;
  logic [7:0] cnf_q, cnf_d;
  logic [IRQ_W-1:0] ist_q, ist_d;
  logic [IRQ_W-1:0] ien_q, ien_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  iebd_state_t st_q, st_d;
  logic [LEN_W-1:0] rem_q, rem_d;
  logic [MEM_ADDR_W-1:0] ofs_q, ofs_d;
  logic [MEM_ADDR_W-1:0] iso_ofs_q, iso_ofs_d;
  logic [MEM_ADDR_W-1:0] mem_addr_q, mem_addr_d;
  logic mem_rd_q, mem_rd_d;
  logic [7:0] tx_data_q, tx_data_d;
  logic tx_valid_q, tx_valid_d;
  logic tx_end_q, tx_end_d;
  logic nak_q, nak_d;
  logic stall_q, stall_d;
  logic pid1_q, pid1_d;

  // ----------------------------------------------------------------
  // decode of configuration
  // ----------------------------------------------------------------
  logic ep_en, is_iso, ep_stall, nak_flag, double_buffer_select;
  logic [LEN_W-1:0] pkt_len, len_clamped, size_len;
  logic [MEM_ADDR_W-1:0] cur_addr, size_bytes, ofs_next;
  logic done_ev, nak_ev, stall_ev, ovf_ev, tog_ev;

  always_comb begin
    ep_en = cnf_q[CNF_EN_BIT];
    is_iso = cnf_q[CNF_ISO_BIT];
    ep_stall = !is_iso && cnf_q[CNF_STALL_BIT];
    double_buffer_select = !is_iso && cnf_q[CNF_DOUBLE_BUFFER_SELECT_BIT];
    nak_flag = cnt_q[CNT_NAK_BIT];
    size_len = {2'h0, size_bytes};
    // non-iso packet cannot exceed one X buffer
    len_clamped = (!is_iso && pkt_len > size_len) ? size_len : pkt_len;
  end

  iebd_len_calc u_len (
    .count_i(cnt_q[CNT_W-1:0]),
    .bytes_per_sample_i(cnf_q[BPS_W-1:0]),
    .iso_i(is_iso),
    .len_o(pkt_len)
  );

  iebd_addr_gen u_addr (
    .base_hi_i(bax_q),
    .size_units_i(siz_q),
    .iso_i(is_iso),
    .ofs_i(ofs_q),
    .addr_o(cur_addr),
    .size_bytes_o(size_bytes),
    .ofs_next_o(ofs_next)
  );

  // ----------------------------------------------------------------
  // transmit sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    rem_d = rem_q;
    ofs_d = ofs_q;
    iso_ofs_d = iso_ofs_q;
    mem_addr_d = mem_addr_q;
    mem_rd_d = 1'b0;
    tx_data_d = tx_data_q;
    tx_valid_d = 1'b0;
    tx_end_d = 1'b0;
    nak_d = 1'b0;
    stall_d = 1'b0;
    done_ev = 1'b0;
    nak_ev = 1'b0;
    stall_ev = 1'b0;
    ovf_ev = 1'b0;
    tog_ev = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (IN_TOKEN_I && ep_en) begin
          if (ep_stall) begin
            stall_d = 1'b1;
            stall_ev = 1'b1;
          end else if (!is_iso && nak_flag) begin
            nak_d = 1'b1;
            nak_ev = 1'b1;
          end else begin
            // iso sends regardless of the no-ack flag
            rem_d = len_clamped;
            // only X is served, whatever the double-buffer bit
            ofs_d = is_iso ? iso_ofs_q : '0;
            ovf_ev = is_iso && (pkt_len > size_len);
            st_d = (len_clamped == '0) ? ST_FIN : ST_READ;
          end
        end
      end
      ST_READ: begin
        mem_addr_d = cur_addr;
        mem_rd_d = 1'b1;
        ofs_d = ofs_next;
        st_d = ST_SEND;
      end
      ST_SEND: begin
        tx_data_d = MEM_DATA_I;
        tx_valid_d = 1'b1;
        rem_d = rem_q - 13'h0001;
        st_d = (rem_q == 13'h0001) ? ST_FIN : ST_READ;
      end
      ST_FIN: begin
        tx_end_d = 1'b1;
        if (is_iso) begin
          iso_ofs_d = ofs_q;
          done_ev = 1'b1;
          st_d = ST_IDLE;
        end else begin
          st_d = ST_WAIT_ACK;
        end
      end
      ST_WAIT_ACK: begin
        if (HOST_ACK_I) begin
          done_ev = 1'b1;
          tog_ev = 1'b1;
          st_d = ST_IDLE;
        end else if (TXN_FAIL_I) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // descriptor and interrupt registers
  // ----------------------------------------------------------------
  logic wr_cnt, wr_cnf;
  logic [IRQ_W-1:0] ev_vec, clr_vec;

  always_comb begin
    wr_cnt = WR_I && (ADDR_I == OFS_CNT);
    wr_cnf = WR_I && (ADDR_I == OFS_CNF);
    cnt_d = wr_cnt ? WDATA_I : cnt_q;
    // hardware set wins over a same-cycle software clear
    if (done_ev) begin
      cnt_d[CNT_NAK_BIT] = 1'b1;
    end
    siz_d = (WR_I && ADDR_I == OFS_SIZ) ? WDATA_I : siz_q;
    bax_d = (WR_I && ADDR_I == OFS_BAX) ? WDATA_I : bax_q;
    cnf_d = wr_cnf ? WDATA_I : cnf_q;
    if (tog_ev) begin
      cnf_d[CNF_TOG_BIT] = ~cnf_q[CNF_TOG_BIT];
    end
    if (ovf_ev) begin
      cnf_d[CNF_OVF_BIT] = 1'b1;
    end
    // data pid only for non-iso, kept in a flop for the output
    pid1_d = cnf_d[CNF_TOG_BIT] && !cnf_d[CNF_ISO_BIT];
    ien_d = (WR_I && ADDR_I == OFS_IEN) ? WDATA_I[IRQ_W-1:0] : ien_q;
    ev_vec = '0;
    ev_vec[IRQ_DONE] = done_ev;
    ev_vec[IRQ_NAK] = nak_ev;
    ev_vec[IRQ_STALL] = stall_ev;
    ev_vec[IRQ_OVF] = ovf_ev;
    clr_vec = (WR_I && ADDR_I == OFS_ICLR) ? WDATA_I[IRQ_W-1:0] : '0;
    ist_d = (ist_q & ~clr_vec) | ev_vec;
    irq_d = |(ist_d & ien_d);
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = 8'h00;
    if (RD_I) begin
      case (ADDR_I)
        OFS_CNT: rdata_d = cnt_q;
        OFS_SIZ: rdata_d = siz_q;
        OFS_BAX: rdata_d = bax_q;
        OFS_CNF: rdata_d = cnf_q;
        OFS_IST: rdata_d = {4'h0, ist_q};
        OFS_IEN: rdata_d = {4'h0, ien_q};
        OFS_STAT: rdata_d = {4'h0, double_buffer_select, st_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      cnt_q <= RST_CNT;
      siz_q <= RST_SIZ;
      bax_q <= RST_BAX;
      cnf_q <= RST_CNF;
      ist_q <= '0;
      ien_q <= RST_IEN;
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      st_q <= ST_IDLE;
      rem_q <= '0;
      ofs_q <= '0;
      iso_ofs_q <= '0;
      mem_addr_q <= '0;
      mem_rd_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_valid_q <= 1'b0;
      tx_end_q <= 1'b0;
      nak_q <= 1'b0;
      stall_q <= 1'b0;
      pid1_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      siz_q <= siz_d;
      bax_q <= bax_d;
      cnf_q <= cnf_d;
      ist_q <= ist_d;
      ien_q <= ien_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      st_q <= st_d;
      rem_q <= rem_d;
      ofs_q <= ofs_d;
      iso_ofs_q <= iso_ofs_d;
      mem_addr_q <= mem_addr_d;
      mem_rd_q <= mem_rd_d;
      tx_data_q <= tx_data_d;
      tx_valid_q <= tx_valid_d;
      tx_end_q <= tx_end_d;
      nak_q <= nak_d;
      stall_q <= stall_d;
      pid1_q <= pid1_d;
    end
  end

  always_comb begin
    RDATA_O = rdata_q;
    IRQ_O = irq_q;
    NAK_O = nak_q;
    STALL_O = stall_q;
    MEM_ADDR_O = mem_addr_q;
    MEM_RD_O = mem_rd_q;
    TX_DATA_O = tx_data_q;
    TX_VALID_O = tx_valid_q;
    TX_END_O = tx_end_q;
    TX_PID1_O = pid1_q;
  end
endmodule : iebd_top

// ===== bench/iebd_top_assertions.sv
// Purpose: port checker for the IN endpoint X descriptor
// Assumes: single clock, synchronous active-high reset
// Notes: bound to iebd_top from the bench top file
`timescale 1ns/10ps
module iebd_top_assertions (
  input wire logic SYS_CLK_I,
  input wire logic SRST_I,
  input wire logic IN_TOKEN_I,
  input wire logic NAK_O,
  input wire logic STALL_O,
  input wire logic [iebd_pkg::MEM_ADDR_W-1:0] MEM_ADDR_O,
  input wire logic MEM_RD_O,
  input wire logic TX_VALID_O,
  input wire logic TX_END_O,
  input wire logic TX_PID1_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SRST_I);
  // ----------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------
  property p_nak_cause;
    NAK_O |-> $past(IN_TOKEN_I);
  endproperty
  a_nak_cause: assert property (p_nak_cause)
    else $error("nak without token");
  property p_stall_cause;
    STALL_O |-> $past(IN_TOKEN_I);
  endproperty
  a_stall_cause: assert property (p_stall_cause)
    else $error("stall without token");
  property p_one_answer;
    NAK_O |-> !STALL_O && !TX_VALID_O;
  endproperty
  a_one_answer: assert property (p_one_answer)
    else $error("nak beside another answer");
  // ----------------------------------------------------------------
  // data path
  // ----------------------------------------------------------------
  property p_tx_after_rd;
    MEM_RD_O |=> TX_VALID_O;
  endproperty
  a_tx_after_rd: assert property (p_tx_after_rd)
    else $error("no byte after memory read");
  property p_valid_cause;
    TX_VALID_O |-> $past(MEM_RD_O);
  endproperty
  a_valid_cause: assert property (p_valid_cause)
    else $error("byte without memory read");
  property p_rd_pace;
    MEM_RD_O |=> !MEM_RD_O;
  endproperty
  a_rd_pace: assert property (p_rd_pace)
    else $error("memory reads too close");
  property p_addr_seq;
    MEM_RD_O ##2 MEM_RD_O |-> MEM_ADDR_O == $past(MEM_ADDR_O, 2) + 11'h001
      || MEM_ADDR_O < $past(MEM_ADDR_O, 2);
  endproperty
  a_addr_seq: assert property (p_addr_seq)
    else $error("memory address out of order");
  property p_end_alone;
    TX_END_O |-> !TX_VALID_O && !MEM_RD_O;
  endproperty
  a_end_alone: assert property (p_end_alone)
    else $error("packet end beside data");
  property p_pid_hold;
    TX_VALID_O |-> $stable(TX_PID1_O);
  endproperty
  a_pid_hold: assert property (p_pid_hold)
    else $error("pid changed inside packet");
endmodule : iebd_top_assertions

// ===== bench/iebd_host_model.sv
// Purpose: host and buffer memory seen by the endpoint
// Assumes: memory byte at an address is its low byte xor 5a
// Notes: acks each packet end while ack_en_i is high
`timescale 1ns/10ps
module iebd_host_model (
  input wire logic clk_i,
  input wire logic [10:0] mem_addr_i,
  input wire logic mem_rd_i,
  output logic [7:0] mem_data_o,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  input wire logic tx_end_i,
  input wire logic ack_en_i,
  output logic ack_o,
  output logic [7:0] rx_cnt_o,
  output logic [15:0] rx_sum_o
);
  initial begin
    ack_o = 1'b0;
    rx_cnt_o = 8'h00;
    rx_sum_o = 16'h0000;
  end
  // read data stands while the read strobe is high, inverse otherwise
  always_comb begin
    mem_data_o = mem_rd_i ? (mem_addr_i[7:0] ^ 8'h5a)
      : ~(mem_addr_i[7:0] ^ 8'h5a);
  end
  always @(posedge clk_i) begin
    ack_o <= tx_end_i & ack_en_i;
    if (tx_valid_i) begin
      rx_cnt_o <= rx_cnt_o + 8'h01;
      rx_sum_o <= rx_sum_o + {8'h00, tx_data_i};
    end
  end
endmodule : iebd_host_model

// ===== bench/tb.sv
// Purpose: self-checking bench for the IN endpoint X descriptor
// Assumes: host model supplies memory bytes and acks
// Notes: each scenario task drives and judges its own traffic
`timescale 1ns/10ps
module tb;
  import iebd_pkg::*;
  logic SYS_CLK_I, SRST_I, WR_I, RD_I, IN_TOKEN_I, HOST_ACK_I, ack_en;
  logic [3:0] ADDR_I;
  logic [7:0] WDATA_I, RDATA_O, MEM_DATA_I, TX_DATA_O, rx_cnt;
  logic [10:0] MEM_ADDR_O;
  logic NAK_O, STALL_O, MEM_RD_O, TX_VALID_O, TX_END_O, TX_PID1_O, IRQ_O;
  logic [15:0] rx_sum;
  logic fail_in;
  int fails = 0;
  int checks_done = 0;
  iebd_top i_dut (.SYS_CLK_I(SYS_CLK_I), .SRST_I(SRST_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .IN_TOKEN_I(IN_TOKEN_I), .HOST_ACK_I(HOST_ACK_I), .TXN_FAIL_I(fail_in),
    .NAK_O(NAK_O), .STALL_O(STALL_O), .MEM_ADDR_O(MEM_ADDR_O),
    .MEM_RD_O(MEM_RD_O), .MEM_DATA_I(MEM_DATA_I), .TX_DATA_O(TX_DATA_O),
    .TX_VALID_O(TX_VALID_O), .TX_END_O(TX_END_O), .TX_PID1_O(TX_PID1_O),
    .IRQ_O(IRQ_O));
  iebd_host_model i_host (.clk_i(SYS_CLK_I), .mem_addr_i(MEM_ADDR_O),
    .mem_rd_i(MEM_RD_O), .mem_data_o(MEM_DATA_I), .tx_data_i(TX_DATA_O),
    .tx_valid_i(TX_VALID_O), .tx_end_i(TX_END_O), .ack_en_i(ack_en),
    .ack_o(HOST_ACK_I), .rx_cnt_o(rx_cnt), .rx_sum_o(rx_sum));
  initial begin
    SYS_CLK_I = 1'b0;
    forever #5 SYS_CLK_I = ~SYS_CLK_I;
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic complete_run();
    $display("mismatches %0d checks %0d", fails, checks_done);
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge SYS_CLK_I);
    WR_I <= 1'b0;
    @(posedge SYS_CLK_I);
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge SYS_CLK_I);
    RD_I <= 1'b0;
    #1;
    cmp({8'h00, RDATA_O}, {8'h00, exp});
    @(posedge SYS_CLK_I);
  endtask : rdc
  // token, then judge answer kind, byte count and byte sum
  task automatic pkt(input logic [1:0] kind, input logic [10:0] base,
    input int ofs, input int n, input int size);
    logic [1:0] got;
    logic [7:0] c0;
    logic [10:0] a;
    logic [15:0] s;
    int i;
    c0 = rx_cnt;
    s = rx_sum;
    for (i = 0; i < n; i++) begin
      a = base + 11'((ofs + i) % size);
      s = s + {8'h00, a[7:0] ^ 8'h5a};
    end
    IN_TOKEN_I <= 1'b1;
    @(posedge SYS_CLK_I);
    IN_TOKEN_I <= 1'b0;
    got = 2'd0;
    // handshakes stand only in the cycle right after the token edge
    for (i = 0; i < 500 && got == 2'd0; i++) begin
      #1;
      if (TX_END_O === 1'b1) got = 2'd1;
      if (NAK_O === 1'b1) got = 2'd2;
      if (STALL_O === 1'b1) got = 2'd3;
      @(posedge SYS_CLK_I);
    end
    if (got == 2'd0) begin
      fails++;
      complete_run();
    end
    repeat (4) @(posedge SYS_CLK_I);
    cmp({14'h0000, got}, {14'h0000, kind});
    cmp({8'h00, rx_cnt - c0}, 16'(n));
    cmp(rx_sum, s);
  endtask : pkt
  task automatic t_regs();
    rdc(OFS_CNT, 8'h80);
    rdc(OFS_SIZ, 8'h00);
    rdc(OFS_CNF, 8'h00);
    wr(OFS_BAX, 8'h10);
    rdc(OFS_BAX, 8'h10);
    wr(4'h9, 8'hff);
    rdc(4'h9, 8'h00);
  endtask : t_regs
  task automatic t_bulk();
    wr(OFS_SIZ, 8'h01);
    wr(OFS_CNF, 8'h80);
    wr(OFS_IEN, 8'h01);
    ack_en <= 1'b1;
    wr(OFS_CNT, 8'h03);
    pkt(2'd1, 11'h080, 0, 3, 8);
    rdc(OFS_CNT, 8'h83);
    cmp({15'h0000, TX_PID1_O}, 16'h0001);
    cmp({15'h0000, IRQ_O}, 16'h0001);
    pkt(2'd2, 11'h080, 0, 0, 8);
    rdc(OFS_IST, 8'h03);
    wr(OFS_ICLR, 8'h03);
    rdc(OFS_IST, 8'h00);
    cmp({15'h0000, IRQ_O}, 16'h0000);
    wr(OFS_CNT, 8'h7f);
    pkt(2'd1, 11'h080, 0, 8, 8);
    wr(OFS_CNF, 8'h88);
    pkt(2'd3, 11'h080, 0, 0, 8);
    rdc(OFS_IST, 8'h05);
  endtask : t_bulk
  // failed transaction leaves flag and toggle alone, retry then acked
  task automatic t_retry();
    wr(OFS_CNF, 8'h80);
    ack_en <= 1'b0;
    wr(OFS_CNT, 8'h02);
    pkt(2'd1, 11'h080, 0, 2, 8);
    fail_in <= 1'b1;
    @(posedge SYS_CLK_I);
    fail_in <= 1'b0;
    rdc(OFS_CNT, 8'h02);
    cmp({15'h0000, TX_PID1_O}, 16'h0000);
    ack_en <= 1'b1;
    pkt(2'd1, 11'h080, 0, 2, 8);
    rdc(OFS_CNT, 8'h82);
    cmp({15'h0000, TX_PID1_O}, 16'h0001);
  endtask : t_retry
  task automatic t_iso();
    ack_en <= 1'b0;
    wr(OFS_BAX, 8'h20);
    wr(OFS_CNF, 8'hc1);
    // flag left set on purpose: must not hold back the packet
    wr(OFS_CNT, 8'h82);
    pkt(2'd1, 11'h100, 0, 4, 8);
    cmp({15'h0000, TX_PID1_O}, 16'h0000);
    wr(OFS_CNT, 8'h02);
    pkt(2'd1, 11'h100, 4, 4, 8);
    wr(OFS_CNT, 8'h02);
    pkt(2'd1, 11'h100, 8, 4, 8);
    // ten bytes into an eight-byte ring: wraps and flags overflow
    wr(OFS_CNT, 8'h05);
    pkt(2'd1, 11'h100, 4, 10, 8);
    rdc(OFS_CNF, 8'he1);
    rdc(OFS_IST, 8'h0d);
  endtask : t_iso
  initial begin
    SRST_I = 1'b1;
    ADDR_I = 4'h0;
    WDATA_I = 8'h00;
    WR_I = 1'b0;
    RD_I = 1'b0;
    IN_TOKEN_I = 1'b0;
    fail_in = 1'b0;
    ack_en = 1'b0;
    repeat (6) @(posedge SYS_CLK_I);
    SRST_I <= 1'b0;
    @(posedge SYS_CLK_I);
    t_regs();
    t_bulk();
    t_retry();
    t_iso();
    complete_run();
  end
endmodule : tb
bind iebd_top iebd_top_assertions i_chk (.SYS_CLK_I(SYS_CLK_I),
  .SRST_I(SRST_I), .IN_TOKEN_I(IN_TOKEN_I), .NAK_O(NAK_O),
  .STALL_O(STALL_O), .MEM_ADDR_O(MEM_ADDR_O), .MEM_RD_O(MEM_RD_O),
  .TX_VALID_O(TX_VALID_O), .TX_END_O(TX_END_O), .TX_PID1_O(TX_PID1_O));
